// ===== rtl/gsr_regs.svh
// register offsets, field positions and reset values of the pin and scan register block
//
// How it works
// - pin direction bit: 0 makes the shared pin an input, 1 an output.
// - drive bit: 0 gives open-drain output, 1 gives push-pull output.
// - output level bit sets the level driven on the matching output.
// - read-only input level register returns the present level of each pin.
// - scan mode field: 00 manual, 01 auto, 10 on-the-fly, 11 reserved.
// - start bit 1 steps enabled channels in ascending order; 0 stops stepping.
// - start bit acts only while scan mode selects auto sequencing.
// - manual channel field picks next input; codes with top bit set reserved.
// - auto-scan mask bit 1 includes the channel in the scan, 0 excludes.
// - pin function bit: 0 analog input, 1 digital pin; pin settings need 1.
// - force-analog bit makes every channel analog, overriding all other settings.
`ifndef GSR_REGS_SVH
`define GSR_REGS_SVH

`define GSR_ADDR_W 8
`define GSR_DATA_W 8
`define GSR_CHANS 8

`define GSR_OFF_FORCE 8'h01
`define GSR_OFF_PIN_FUNC 8'h05
`define GSR_OFF_PIN_DIR 8'h07
`define GSR_OFF_DRIVE 8'h09
`define GSR_OFF_OUT_LEVEL 8'h0b
`define GSR_OFF_IN_LEVEL 8'h0d
`define GSR_OFF_SCAN_CTL 8'h10
`define GSR_OFF_MAN_CHAN 8'h11
`define GSR_OFF_SCAN_MASK 8'h12

`define GSR_FORCE_BIT 2
`define GSR_SCAN_GO_BIT 4
`define GSR_MODE_LSB 0
`define GSR_MODE_MSB 1
`define GSR_MAN_CHAN_MSB 3

`define GSR_RESET_VAL 8'h00

`endif

// ===== rtl/gsr_pkg.sv
// types shared by the pin and scan register block
package gsr_pkg;
   typedef enum logic [1:0]
   {
      GSR_MODE_MANUAL = 2'b00,
      GSR_MODE_AUTO = 2'b01,
      GSR_MODE_FLY = 2'b10,
      GSR_MODE_RSVD = 2'b11
   } gsr_mode_t;

   typedef enum logic [0:0]
   {
      GSR_SCAN_IDLE = 1'b0,
      GSR_SCAN_RUN = 1'b1
   } gsr_scan_state_t;
endpackage : gsr_pkg

// ===== rtl/gsr_pin_ctl.sv
// per-channel pad control: function, direction, drive type and input sampling
`timescale 1ns/100ps
`default_nettype none
module gsr_pin_ctl
   import gsr_pkg::*;
#(
   parameter int CHANS = 8
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic force_all_analog,
   input wire logic [CHANS-1:0] pin_func,
   input wire logic [CHANS-1:0] pin_dir,
   input wire logic [CHANS-1:0] drive_type,
   input wire logic [CHANS-1:0] out_level,
   input wire logic [CHANS-1:0] pad_in,
   output logic [CHANS-1:0] pad_out,
   output logic [CHANS-1:0] pad_oe,
   output logic [CHANS-1:0] in_level,
   output logic [CHANS-1:0] analog_en
);
   logic [CHANS-1:0] sync1_r;
   logic [CHANS-1:0] sync2_r;

   genvar g;
   generate
      for (g = 0; g < CHANS; g = g + 1)
      begin : g_chan
         wire digital = pin_func[g] & ~force_all_analog;
         wire drv_out = digital & pin_dir[g];
         assign analog_en[g] = ~digital;
         assign pad_out[g] = out_level[g];
         // open-drain only pulls low; a high level floats to the pullup
         assign pad_oe[g] = drv_out & (drive_type[g] | ~out_level[g]);
      end
   endgenerate

   // pads are asynchronous, two stages before the register reads them
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else
      begin
         sync1_r <= pad_in;
         sync2_r <= sync1_r;
      end
   end

   assign in_level = sync2_r;
endmodule : gsr_pin_ctl
`default_nettype wire

// ===== rtl/gsr_scan_seq.sv
// channel sequencer: manual, auto mask walk and on-the-fly selection
`timescale 1ns/100ps
`default_nettype none
module gsr_scan_seq
   import gsr_pkg::*;
#(
   parameter int CHANS = 8
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] mode,
   input wire logic scan_go,
   input wire logic [3:0] manual_channel_id,
   input wire logic [2:0] fly_channel,
   input wire logic [CHANS-1:0] scan_mask,
   input wire logic conv_done,
   output logic [2:0] chan_r,
   output logic chan_valid_r
);
   gsr_scan_state_t state_r;
   gsr_scan_state_t state_nxt;
   logic [2:0] next_auto;
   logic found;
   logic [2:0] chan_nxt;
   logic valid_nxt;

   // lowest enabled channel above current, else wrap to lowest enabled
   always_comb
   begin
      next_auto = chan_r;
      found = 1'b0;
      for (int i = CHANS - 1; i >= 0; i--)
      begin
         if (scan_mask[i] && (3'(i) > chan_r))
         begin
            next_auto = 3'(i);
            found = 1'b1;
         end
      end
      if (!found)
      begin
         for (int i = CHANS - 1; i >= 0; i--)
         begin
            if (scan_mask[i])
            begin
               next_auto = 3'(i);
               found = 1'b1;
            end
         end
      end
   end

   wire auto_run = (mode == GSR_MODE_AUTO) && scan_go;

   always_comb
   begin
      state_nxt = state_r;
      chan_nxt = chan_r;
      valid_nxt = chan_valid_r;
      case (mode)
         GSR_MODE_MANUAL:
         begin
            state_nxt = GSR_SCAN_IDLE;
            chan_nxt = manual_channel_id[2:0];
            valid_nxt = ~manual_channel_id[3];
         end
         GSR_MODE_AUTO:
         begin
            case (state_r)
               GSR_SCAN_IDLE:
               begin
                  valid_nxt = 1'b0;
                  if (auto_run && found)
                  begin
                     state_nxt = GSR_SCAN_RUN;
                     chan_nxt = next_auto;
                     valid_nxt = 1'b1;
                  end
               end
               GSR_SCAN_RUN:
               begin
                  if (!auto_run || !found)
                  begin
                     state_nxt = GSR_SCAN_IDLE;
                     valid_nxt = 1'b0;
                  end
                  else if (conv_done)
                  begin
                     chan_nxt = next_auto;
                  end
               end
               default:
               begin
                  state_nxt = GSR_SCAN_IDLE;
               end
            endcase
         end
         GSR_MODE_FLY:
         begin
            state_nxt = GSR_SCAN_IDLE;
            chan_nxt = fly_channel;
            valid_nxt = 1'b1;
         end
         default:
         begin
            state_nxt = GSR_SCAN_IDLE;
            valid_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= GSR_SCAN_IDLE;
         chan_r <= 3'h0;
         chan_valid_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         chan_r <= chan_nxt;
         chan_valid_r <= valid_nxt;
      end
   end
endmodule : gsr_scan_seq
`default_nettype wire

// ===== rtl/gsr_top.sv
// register bank for shared pins and channel sequencer, with its pad and scan logic
`timescale 1ns/100ps
`default_nettype none
`include "gsr_regs.svh"
module gsr_top
   import gsr_pkg::*;
#(
   parameter int CHANS = `GSR_CHANS
)
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic [`GSR_ADDR_W-1:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [`GSR_DATA_W-1:0] REG_WDATA,
   output logic [`GSR_DATA_W-1:0] REG_RDATA,
   input wire logic [CHANS-1:0] PAD_IN,
   output logic [CHANS-1:0] PAD_OUT,
   output logic [CHANS-1:0] PAD_OE,
   output logic [CHANS-1:0] ANALOG_EN,
   input wire logic CONV_DONE,
   input wire logic [2:0] FLY_CHANNEL,
   output logic [2:0] CONV_CHANNEL,
   output logic CONV_CHANNEL_VALID
);
   // ******************************************************************
   // register storage
   // ******************************************************************
   logic force_all_analog_r;
   logic [CHANS-1:0] pin_func_r;
   logic [CHANS-1:0] pin_direction_r;
   logic [CHANS-1:0] output_drive_type_r;
   logic [CHANS-1:0] output_level_r;
   logic scan_go_r;
   logic [1:0] scan_mode_select_r;
   logic [3:0] manual_channel_id_r;
   logic [CHANS-1:0] auto_scan_mask_r;
   logic [CHANS-1:0] input_level;
   logic [`GSR_DATA_W-1:0] rdata_nxt;

   // ******************************************************************
   // address decode
   // ******************************************************************
   wire wr_force = REG_WR && (REG_ADDR == `GSR_OFF_FORCE);
   wire wr_func = REG_WR && (REG_ADDR == `GSR_OFF_PIN_FUNC);
   wire wr_dir = REG_WR && (REG_ADDR == `GSR_OFF_PIN_DIR);
   wire wr_drive = REG_WR && (REG_ADDR == `GSR_OFF_DRIVE);
   wire wr_level = REG_WR && (REG_ADDR == `GSR_OFF_OUT_LEVEL);
   wire wr_scan = REG_WR && (REG_ADDR == `GSR_OFF_SCAN_CTL);
   wire wr_man = REG_WR && (REG_ADDR == `GSR_OFF_MAN_CHAN);
   wire wr_mask = REG_WR && (REG_ADDR == `GSR_OFF_SCAN_MASK);

   // ******************************************************************
   // writable registers
   // ******************************************************************
   always_ff @(posedge CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         force_all_analog_r <= 1'b0;
         pin_func_r <= `GSR_RESET_VAL;
         pin_direction_r <= `GSR_RESET_VAL;
         output_drive_type_r <= `GSR_RESET_VAL;
         output_level_r <= `GSR_RESET_VAL;
         scan_go_r <= 1'b0;
         scan_mode_select_r <= 2'h0;
         manual_channel_id_r <= 4'h0;
         auto_scan_mask_r <= `GSR_RESET_VAL;
      end
      else
      begin
         if (wr_force)
            force_all_analog_r <= REG_WDATA[`GSR_FORCE_BIT];
         if (wr_func)
            pin_func_r <= REG_WDATA;
         if (wr_dir)
            pin_direction_r <= REG_WDATA;
         if (wr_drive)
            output_drive_type_r <= REG_WDATA;
         if (wr_level)
            output_level_r <= REG_WDATA;
         if (wr_scan)
         begin
            scan_go_r <= REG_WDATA[`GSR_SCAN_GO_BIT];
            scan_mode_select_r <= REG_WDATA[`GSR_MODE_MSB:`GSR_MODE_LSB];
         end
         if (wr_man)
            manual_channel_id_r <= REG_WDATA[`GSR_MAN_CHAN_MSB:0];
         if (wr_mask)
            auto_scan_mask_r <= REG_WDATA;
      end
   end

   // ******************************************************************
   // read mux, reserved bits and unmapped addresses read zero
   // ******************************************************************
   always_comb
   begin
      rdata_nxt = 8'h00;
      case (REG_ADDR)
         `GSR_OFF_FORCE: rdata_nxt[`GSR_FORCE_BIT] = force_all_analog_r;
         `GSR_OFF_PIN_FUNC: rdata_nxt = pin_func_r;
         `GSR_OFF_PIN_DIR: rdata_nxt = pin_direction_r;
         `GSR_OFF_DRIVE: rdata_nxt = output_drive_type_r;
         `GSR_OFF_OUT_LEVEL: rdata_nxt = output_level_r;
         `GSR_OFF_IN_LEVEL: rdata_nxt = input_level;
         `GSR_OFF_SCAN_CTL:
         begin
            rdata_nxt[`GSR_SCAN_GO_BIT] = scan_go_r;
            rdata_nxt[`GSR_MODE_MSB:`GSR_MODE_LSB] = scan_mode_select_r;
         end
         `GSR_OFF_MAN_CHAN: rdata_nxt[`GSR_MAN_CHAN_MSB:0] = manual_channel_id_r;
         `GSR_OFF_SCAN_MASK: rdata_nxt = auto_scan_mask_r;
         default: rdata_nxt = 8'h00;
      endcase
   end

   // read data registered so it is stable one cycle after the address
   always_ff @(posedge CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
         REG_RDATA <= 8'h00;
      else
         REG_RDATA <= rdata_nxt;
   end

   // ******************************************************************
   // pad and sequencer logic
   // ******************************************************************
   gsr_pin_ctl #(.CHANS(CHANS)) u_pins
   (
      .clk(CLK),
      .rst(SYS_RST),
      .force_all_analog(force_all_analog_r),
      .pin_func(pin_func_r),
      .pin_dir(pin_direction_r),
      .drive_type(output_drive_type_r),
      .out_level(output_level_r),
      .pad_in(PAD_IN),
      .pad_out(PAD_OUT),
      .pad_oe(PAD_OE),
      .in_level(input_level),
      .analog_en(ANALOG_EN)
   );

   // the manual channel is not checked against pin function; host keeps them apart
   gsr_scan_seq #(.CHANS(CHANS)) u_seq
   (
      .clk(CLK),
      .rst(SYS_RST),
      .mode(scan_mode_select_r),
      .scan_go(scan_go_r),
      .manual_channel_id(manual_channel_id_r),
      .fly_channel(FLY_CHANNEL),
      .scan_mask(auto_scan_mask_r),
      .conv_done(CONV_DONE),
      .chan_r(CONV_CHANNEL),
      .chan_valid_r(CONV_CHANNEL_VALID)
   );
endmodule : gsr_top
`default_nettype wire

// ===== bench/gsr_top_checker.sv
// assertion checker for the pin and scan register block
`timescale 1ns/100ps
`default_nettype none
module gsr_top_checker
   import gsr_pkg::*;
#(
   parameter int CHANS = 8
)
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   input wire logic [7:0] REG_RDATA,
   input wire logic [CHANS-1:0] PAD_IN,
   input wire logic [CHANS-1:0] PAD_OUT,
   input wire logic [CHANS-1:0] PAD_OE,
   input wire logic [CHANS-1:0] ANALOG_EN,
   input wire logic [2:0] FLY_CHANNEL,
   input wire logic [2:0] CONV_CHANNEL,
   input wire logic CONV_CHANNEL_VALID
);
   // shadow of what software wrote, so pad and scan outputs can be predicted
   logic [7:0] sh_r [0:18];
   logic [2:0] up_r;
   logic [7:0] ctl;
   logic [7:0] man;
   logic [7:0] msk;
   assign ctl = sh_r[16];
   assign man = sh_r[17];
   assign msk = sh_r[18];
   always_ff @(posedge CLK or posedge SYS_RST)
      if (SYS_RST)
      begin
         sh_r <= '{default: 8'h00};
         up_r <= 3'h0;
      end
      else
      begin
         if (REG_WR && REG_ADDR <= 8'h12)
            sh_r[REG_ADDR[4:0]] <= REG_WDATA;
         if (up_r != 3'h7)
            up_r <= up_r + 3'h1;
      end
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   a_pad_drive: assert property (PAD_OE == ((sh_r[1][2] ? 8'h00 : sh_r[5])
      & sh_r[7] & (sh_r[9] | ~sh_r[11])) && (PAD_OE & PAD_OUT) == (PAD_OE & sh_r[11]))
      else $error("pad drive wrong");
   a_analog_sel: assert property (ANALOG_EN == (sh_r[1][2] ? 8'hff : ~sh_r[5]))
      else $error("analog enable wrong");
   a_input_sync: assert property (up_r == 3'h7 && $stable(PAD_IN) && $past(PAD_IN, 2) == PAD_IN
      && $past(PAD_IN, 3) == PAD_IN && $past(REG_ADDR) == 8'h0d |-> REG_RDATA == PAD_IN)
      else $error("input level wrong");
   a_dir_readback: assert property ((REG_WR && REG_ADDR == 8'h07) ##1 (!REG_WR && REG_ADDR == 8'h07)
      |=> REG_RDATA == $past(REG_WDATA, 2))
      else $error("direction readback wrong");
   a_rsvd_zero: assert property ($past(REG_ADDR) == 8'h10 |-> (REG_RDATA & 8'hec) == 8'h00)
      else $error("reserved bits set");
   a_manual_chan: assert property (ctl[1:0] == 2'b00 |=> CONV_CHANNEL == $past(man[2:0])
      && CONV_CHANNEL_VALID == !$past(man[3]))
      else $error("manual channel wrong");
   a_fly_chan: assert property (ctl[1:0] == 2'b10
      |=> CONV_CHANNEL == $past(FLY_CHANNEL) && CONV_CHANNEL_VALID)
      else $error("fly channel wrong");
   a_scan_idle: assert property (ctl[1:0] == 2'b11
      || ctl[1:0] == 2'b01 && (!ctl[4] || msk == 8'h00) |=> !CONV_CHANNEL_VALID)
      else $error("scan not idle");
   a_auto_mask: assert property (CONV_CHANNEL_VALID && ctl[4:0] == 5'h11 && $past(ctl[4:0]) == 5'h11
      && $stable(msk) |-> msk[CONV_CHANNEL])
      else $error("auto channel not enabled");
endmodule : gsr_top_checker
bind gsr_top gsr_top_checker #(.CHANS(CHANS)) u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
   .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .PAD_IN(PAD_IN), .PAD_OUT(PAD_OUT),
   .PAD_OE(PAD_OE), .ANALOG_EN(ANALOG_EN), .FLY_CHANNEL(FLY_CHANNEL), .CONV_CHANNEL(CONV_CHANNEL),
   .CONV_CHANNEL_VALID(CONV_CHANNEL_VALID));
`default_nettype wire

// ===== bench/gsr_pad_model.sv
// board side of the shared pins: pull-ups and an optional outside driver
`timescale 1ns/100ps
`default_nettype none
module gsr_pad_model
(
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   output logic [7:0] pad_level
);
   // released open-drain pins float up through the pull-ups
   assign pad_level = (pad_oe & pad_out) | (~pad_oe & ((ext_en & ext_val) | ~ext_en));
endmodule : gsr_pad_model
`default_nettype wire

// ===== bench/gsr_top_tb.sv
// self-checking bench for the pin and scan register block
`timescale 1ns/100ps
`default_nettype none
module gsr_top_tb
   import gsr_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr = 1'b0;
   logic done = 1'b0;
   logic valid;
   logic [2:0] fly = 3'h0;
   logic [2:0] chan;
   logic [7:0] addr = 8'h00, wdata = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
   logic [7:0] rdata, pad_in, pad_out, pad_oe, an_en;
   logic [23:0] tbl [8] = '{24'h075a5a, 24'h095a5a, 24'h0b5a5a, 24'h10ff13, 24'h11ff0f, 24'h125a5a,
      24'h0d00ff, 24'h20ff00};
   int n_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   always #10 clk = ~clk;
   gsr_top dut (.CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RDATA(rdata),
      .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe), .ANALOG_EN(an_en), .CONV_DONE(done),
      .FLY_CHANNEL(fly), .CONV_CHANNEL(chan), .CONV_CHANNEL_VALID(valid));
   gsr_pad_model u_pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_en(ext_en), .ext_val(ext_val),
      .pad_level(pad_in));
   task automatic stop_test;
      $display("compares %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      addr = a;
      @(negedge clk);
      check($sformatf("reg %h", a), rdata, exp);
   endtask : rd_reg
   // bit 3 of exp is the valid flag; channel only compared while valid
   task automatic see(input logic [3:0] exp);
      @(negedge clk);
      check("channel", exp[3] ? {4'h0, valid, chan} : {7'h0, valid}, exp[3] ? {4'h0, exp} : 8'h00);
   endtask : see
   task automatic pulse;
      @(negedge clk);
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
   endtask : pulse
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         n_errors++;
         stop_test();
      end
   end
   initial
   begin
      repeat (16) @(negedge clk);
      rst = 1'b0;
      foreach (tbl[i])
         rd_reg(tbl[i][23:16], tbl[i][23:16] == 8'h0d ? 8'hff : 8'h00);
      foreach (tbl[i])
      begin
         wr_reg(tbl[i][23:16], tbl[i][15:8]);
         rd_reg(tbl[i][23:16], tbl[i][7:0]);
         wr_reg(tbl[i][23:16], 8'h00);
      end
      $display("test registers done");
      wr_reg(8'h05, 8'hff);
      wr_reg(8'h07, 8'hf0);
      wr_reg(8'h09, 8'hc0);
      wr_reg(8'h0b, 8'ha0);
      ext_en = 8'h0f;
      ext_val = 8'h05;
      check("oe", pad_oe, 8'hd0);
      check("out", pad_out & pad_oe, 8'h80);
      repeat (3) @(negedge clk);
      rd_reg(8'h0d, 8'ha5);
      wr_reg(8'h01, 8'h04);
      ext_en = 8'h00;
      check("analog", an_en, 8'hff);
      check("oe", pad_oe, 8'h00);
      repeat (3) @(negedge clk);
      rd_reg(8'h0d, 8'hff);
      wr_reg(8'h01, 8'h00);
      wr_reg(8'h05, 8'h0f);
      check("analog", an_en, 8'hf0);
      check("oe", pad_oe, 8'h00);
      wr_reg(8'h05, 8'h00);
      $display("test pads done");
      wr_reg(8'h12, 8'h29);
      for (int id = 0; id < 16; id++)
      begin
         wr_reg(8'h11, 8'(id));
         see({~id[3], id[2:0]});
      end
      wr_reg(8'h11, 8'h02);
      wr_reg(8'h10, 8'h10);
      see(4'ha);
      wr_reg(8'h10, 8'h02);
      for (int c = 0; c < 8; c++)
      begin
         fly = 3'(c);
         see({1'b1, 3'(c)});
      end
      wr_reg(8'h10, 8'h03);
      see(4'h0);
      $display("test select done");
      wr_reg(8'h11, 8'h00);
      wr_reg(8'h10, 8'h00);
      see(4'h8);
      wr_reg(8'h10, 8'h01);
      see(4'h0);
      wr_reg(8'h10, 8'h11);
      see(4'hb);
      pulse();
      see(4'hd);
      pulse();
      see(4'h8);
      pulse();
      see(4'hb);
      wr_reg(8'h10, 8'h01);
      see(4'h0);
      wr_reg(8'h12, 8'h00);
      wr_reg(8'h10, 8'h11);
      see(4'h0);
      $display("test auto done");
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      rd_reg(8'h07, 8'h00);
      see(4'h8);
      $display("test reset done");
      stop_test();
   end
endmodule : gsr_top_tb
`default_nettype wire
